// *** common/lbt_consts.svh ***
`ifndef LBT_CONSTS_SVH
`define LBT_CONSTS_SVH

// register offsets (byte addresses)
`define LBT_ADDR_CTRL 8'h00
`define LBT_ADDR_DATA 8'h04
`define LBT_ADDR_THRESH 8'h08
`define LBT_ADDR_DUR 8'h0c
`define LBT_ADDR_STATUS 8'h10
`define LBT_ADDR_BITERR 8'h14
`define LBT_ADDR_ERRSEC 8'h18
`define LBT_ADDR_ELAPSED 8'h1c
`define LBT_ADDR_LOOPCODE 8'h20
`define LBT_ADDR_CAPS 8'h24

// ctrl fields
`define LBT_CTRL_START 0
`define LBT_CTRL_STOP 1
`define LBT_CTRL_PAT_LO 2
`define LBT_CTRL_NONLATCH 5
`define LBT_CTRL_SEQ 6
`define LBT_CTRL_LAST 7
`define LBT_CTRL_LOOPOUT 8

// reset values
`define LBT_OCTET_DEFAULT 8'h32
`define LBT_ALT_DEFAULT 8'hff
`define LBT_THRESH_DEFAULT 24'd56
`define LBT_DUR_DEFAULT 17'd1
`define LBT_LOOPCODE_DEFAULT 8'h5a

// limits
`define LBT_ERR_SAT 8'd255
`define LBT_ALT_RUN 7'd100
`define LBT_SETUP_OCTETS 8'd32
`define LBT_MAX_TESTS_VAR 7'd8
`define LBT_MAX_SYSTEM 11'd1024

// timing
`define LBT_CLK_MHZ 100
`define LBT_SECOND_US 1000000
`define LBT_SECOND_CYC (`LBT_CLK_MHZ * `LBT_SECOND_US)

`endif

// *** common/lbt_pkg.sv ***
package lbt_pkg;
    typedef enum logic [2:0] {
        LBT_PAT_LONG,
        LBT_PAT_SHORT,
        LBT_PAT_OCTET,
        LBT_PAT_ALT
    } lbt_pattern_t;

    typedef enum logic [1:0] {
        LBT_ASSOC_NONE,
        LBT_ASSOC_FAR_END,
        LBT_ASSOC_TEST,
        LBT_ASSOC_FAR_END_AND_TEST
    } lbt_assoc_t;

    typedef enum logic [1:0] {
        LBT_DONE_NONE,
        LBT_DONE_TIME,
        LBT_DONE_ERROR,
        LBT_DONE_STOPPED
    } lbt_done_t;
endpackage

// *** logic/lbt_tester.sv ***
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "lbt_consts.svh"

// Contract
// - long pseudo-random pattern of 2047 bits sent until stopped.
// - short pseudo-random pattern of 511 bits sent until stopped.
// - non-latching variants interleave loop command with test data throughout.
// - octet mode repeats configured octet, default 32 hex, latched only.
// - byte_zero_alternating_pattern mode sends 100 data octets, 100 zero octets, default ff.
// - returned stream compared bitwise; every mismatch adds one error.
// - bit error counter saturates at 255, never wraps.
// - 255 or more errors within one second ends the test.
// - transmit stream continuous with no gaps during a test.
// - any element can be commanded into latched loopback and out.
// - far-end loop only: out of service, looped, far end.
// - test only: out of service, looped, test in progress.
// - both: out of service, looped, far end and test.
// - concurrent tests per card limited to 1, 8 or 64 by variant.
// - local test sends loopback code first, then runs for set period.
// - far-end loop code deactivates link and loops received data back while no test runs.
// - system supports at most 1024 concurrent local link tests.
// - results kept per point: errors, errored seconds, duration, status.
// - error threshold defaults to 56; test stops once exceeded.
// - sequence of points aborts at the first failed point.
// - no signalling traffic carried while a test runs.
module lbt_tester
    import lbt_pkg::*;
#(
    parameter int SECOND_CYCLES = `LBT_SECOND_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic bit_en_in,
    input wire logic rx_bit_in,
    input wire logic far_loop_code_in,
    input wire logic [1:0] card_variant_in,
    input wire logic [6:0] tests_active_in,
    input wire logic [10:0] system_tests_in,
    input wire logic sig_tx_bit_in,
    output logic tx_bit_out,
    output logic link_active_out,
    output logic out_of_service_disabled_out,
    output logic looped_state_out,
    output lbt_assoc_t associated_state_out,
    output logic test_running_out
);

    // ************************************************
    // synchronisers
    // ************************************************
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [1:0] var1_reg;
    logic [1:0] var2_reg;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            var1_reg <= 2'h0;
            var2_reg <= 2'h0;
        end else begin
            sync1_reg <= {far_loop_code_in, rx_bit_in, bit_en_in};
            sync2_reg <= sync1_reg;
            var1_reg <= card_variant_in;
            var2_reg <= var1_reg;
        end
    end
    wire bit_en_s = sync2_reg[0];
    wire rx_bit_s = sync2_reg[1];
    wire far_code_s = sync2_reg[2];

    // ************************************************
    // registers
    // ************************************************
    logic [2:0] pat_reg;
    logic nonlatch_reg;
    logic seq_reg;
    logic last_reg;
    logic loop_latched_reg;
    logic [7:0] data_reg;
    logic data_given_reg;
    logic [23:0] thresh_reg;
    logic [16:0] dur_reg;
    logic [7:0] loopcode_reg;
    logic running_reg;
    logic setup_reg;
    logic seq_abort_reg;
    lbt_done_t done_reg;
    logic [7:0] biterr_reg;
    logic [23:0] total_err_reg;
    logic [16:0] errsec_reg;
    logic [16:0] elapsed_reg;
    logic [7:0] sec_err_reg;
    logic [31:0] sec_cnt_reg;
    logic [10:0] lfsr_reg;
    logic [7:0] chk_hist_reg;
    logic [2:0] bitpos_reg;
    logic [6:0] alt_cnt_reg;
    logic alt_zero_reg;
    logic [7:0] setup_cnt_reg;
    logic [7:0] ref_hist_reg;
    logic interleave_reg;
    logic [2:0] lc_pos_reg;

    wire [6:0] max_tests = (var2_reg == 2'h0) ? 7'd1 :
        (var2_reg == 2'h1) ? `LBT_MAX_TESTS_VAR : 7'd64;
    wire admit = (tests_active_in < max_tests) && (system_tests_in < `LBT_MAX_SYSTEM);
    wire wr_ctrl = wr_in && (addr_in == `LBT_ADDR_CTRL);
    wire start_req = wr_ctrl && wdata_in[`LBT_CTRL_START] && !running_reg && admit;
    wire stop_req = wr_ctrl && wdata_in[`LBT_CTRL_STOP];
    wire [2:0] new_pat = wdata_in[`LBT_CTRL_PAT_LO +: 3];
    wire latched_pat = (new_pat == 3'(LBT_PAT_OCTET)) || (new_pat == 3'(LBT_PAT_ALT));
    wire start_ok = start_req && !(latched_pat && wdata_in[`LBT_CTRL_NONLATCH])
        && !(seq_abort_reg && wdata_in[`LBT_CTRL_SEQ]);
    wire [7:0] default_data = (new_pat == 3'(LBT_PAT_ALT)) ? `LBT_ALT_DEFAULT
        : `LBT_OCTET_DEFAULT;

    // ************************************************
    // pattern generation
    // ************************************************
    // feedback taps
    wire long_fb = lfsr_reg[10] ^ lfsr_reg[8];
    wire short_fb = lfsr_reg[8] ^ lfsr_reg[4];
    wire prbs_long = (pat_reg == 3'(LBT_PAT_LONG));
    wire prbs_bit = lfsr_reg[prbs_long ? 10 : 8];
    wire [10:0] lfsr_next = prbs_long ? {lfsr_reg[9:0], long_fb}
        : {2'h0, lfsr_reg[7:0], short_fb};
    wire octet_bit = alt_zero_reg ? 1'b0 : data_reg[3'd7 - bitpos_reg];
    wire code_bit = loopcode_reg[3'd7 - lc_pos_reg];
    // code octet interleaved between prbs octets
    wire use_code = setup_reg || (nonlatch_reg && interleave_reg);
    wire pat_bit = (pat_reg[1]) ? octet_bit : prbs_bit;
    wire tx_next = use_code ? code_bit : pat_bit;
    wire octet_end = (bitpos_reg == 3'd7);
    wire checking = running_reg && chk_hist_reg[7];
    wire mismatch = checking && bit_en_s && (rx_bit_s != ref_hist_reg[7]);
    wire sec_tick = (sec_cnt_reg == 32'(SECOND_CYCLES - 1));
    wire [7:0] biterr_inc = (biterr_reg == `LBT_ERR_SAT) ? biterr_reg : biterr_reg + 8'd1;
    wire [7:0] sec_inc = (sec_err_reg == `LBT_ERR_SAT) ? sec_err_reg : sec_err_reg + 8'd1;
    // too many errors in one second
    wire burst_fail = running_reg && (sec_inc == `LBT_ERR_SAT) && mismatch;
    wire thresh_fail = running_reg && mismatch && ((total_err_reg + 24'd1) > thresh_reg);
    wire time_done = running_reg && sec_tick && ((elapsed_reg + 17'd1) >= dur_reg);
    wire err_end = burst_fail || thresh_fail;

    // ************************************************
    // control and counters
    // ************************************************
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pat_reg <= 3'(LBT_PAT_LONG);
            nonlatch_reg <= 1'b0;
            seq_reg <= 1'b0;
            last_reg <= 1'b0;
            loop_latched_reg <= 1'b0;
            data_reg <= `LBT_OCTET_DEFAULT;
            data_given_reg <= 1'b0;
            thresh_reg <= `LBT_THRESH_DEFAULT;
            dur_reg <= `LBT_DUR_DEFAULT;
            loopcode_reg <= `LBT_LOOPCODE_DEFAULT;
            running_reg <= 1'b0;
            setup_reg <= 1'b0;
            seq_abort_reg <= 1'b0;
            done_reg <= LBT_DONE_NONE;
        end else begin
            if (wr_in && addr_in == `LBT_ADDR_DATA) begin
                data_reg <= wdata_in[7:0];
                data_given_reg <= 1'b1;
            end
            if (wr_in && addr_in == `LBT_ADDR_THRESH) begin
                thresh_reg <= wdata_in[23:0];
            end
            if (wr_in && addr_in == `LBT_ADDR_DUR) begin
                dur_reg <= (wdata_in[16:0] == 17'h0) ? `LBT_DUR_DEFAULT : wdata_in[16:0];
            end
            if (wr_in && addr_in == `LBT_ADDR_LOOPCODE) begin
                loopcode_reg <= wdata_in[7:0];
            end
            // latch element loop in or out
            if (wr_ctrl && !running_reg) begin
                loop_latched_reg <= !wdata_in[`LBT_CTRL_LOOPOUT]
                    && !wdata_in[`LBT_CTRL_NONLATCH] && (loop_latched_reg
                    || wdata_in[`LBT_CTRL_START]);
            end
            if (start_ok) begin
                pat_reg <= new_pat;
                nonlatch_reg <= wdata_in[`LBT_CTRL_NONLATCH];
                seq_reg <= wdata_in[`LBT_CTRL_SEQ];
                last_reg <= wdata_in[`LBT_CTRL_LAST];
                if (!data_given_reg) begin
                    data_reg <= default_data;
                end
                data_given_reg <= 1'b0;
                setup_reg <= 1'b1;
                running_reg <= 1'b1;
                done_reg <= LBT_DONE_NONE;
                seq_abort_reg <= 1'b0;
            end else if (setup_reg && bit_en_s && octet_end
                    && setup_cnt_reg == `LBT_SETUP_OCTETS - 8'd1) begin
                setup_reg <= 1'b0;
            end
            if (running_reg && (stop_req || err_end || time_done)) begin
                running_reg <= 1'b0;
                setup_reg <= 1'b0;
                done_reg <= stop_req ? LBT_DONE_STOPPED : err_end ? LBT_DONE_ERROR
                    : LBT_DONE_TIME;
                seq_abort_reg <= seq_reg && err_end && !last_reg;
            end
            if (stop_req && !running_reg) begin
                seq_abort_reg <= 1'b0;
            end
        end
    end

    // one bit per enable, no gaps
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            lfsr_reg <= 11'h7ff;
            bitpos_reg <= 3'h0;
            alt_cnt_reg <= 7'h0;
            alt_zero_reg <= 1'b0;
            setup_cnt_reg <= 8'h0;
            ref_hist_reg <= 8'h0;
            interleave_reg <= 1'b0;
            lc_pos_reg <= 3'h0;
            chk_hist_reg <= 8'h0;
        end else if (start_ok) begin
            lfsr_reg <= 11'h7ff;
            bitpos_reg <= 3'h0;
            alt_cnt_reg <= 7'h0;
            alt_zero_reg <= 1'b0;
            setup_cnt_reg <= 8'h0;
            interleave_reg <= 1'b0;
            lc_pos_reg <= 3'h0;
            chk_hist_reg <= 8'h0;
        end else if (bit_en_s && running_reg) begin
            bitpos_reg <= bitpos_reg + 3'd1;
            lc_pos_reg <= lc_pos_reg + 3'd1;
            chk_hist_reg <= {chk_hist_reg[6:0], !use_code};
            ref_hist_reg <= {ref_hist_reg[6:0], pat_bit};
            if (!use_code && !pat_reg[1]) begin
                lfsr_reg <= (lfsr_next == 11'h0) ? 11'h7ff : lfsr_next;
            end
            if (octet_end) begin
                if (setup_reg) begin
                    setup_cnt_reg <= setup_cnt_reg + 8'd1;
                end else if (nonlatch_reg) begin
                    interleave_reg <= !interleave_reg;
                end
                if (!use_code && pat_reg == 3'(LBT_PAT_ALT)) begin
                    if (alt_cnt_reg == `LBT_ALT_RUN - 7'd1) begin
                        alt_cnt_reg <= 7'h0;
                        alt_zero_reg <= !alt_zero_reg;
                    end else begin
                        alt_cnt_reg <= alt_cnt_reg + 7'd1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            biterr_reg <= 8'h0;
            total_err_reg <= 24'h0;
            errsec_reg <= 17'h0;
            elapsed_reg <= 17'h0;
            sec_err_reg <= 8'h0;
            sec_cnt_reg <= 32'h0;
        end else if (start_ok) begin
            biterr_reg <= 8'h0;
            total_err_reg <= 24'h0;
            errsec_reg <= 17'h0;
            elapsed_reg <= 17'h0;
            sec_err_reg <= 8'h0;
            sec_cnt_reg <= 32'h0;
        end else if (running_reg) begin
            sec_cnt_reg <= sec_tick ? 32'h0 : sec_cnt_reg + 32'd1;
            if (mismatch && bit_en_s) begin
                biterr_reg <= biterr_inc;
                total_err_reg <= total_err_reg + 24'd1;
            end
            if ((sec_tick || err_end || stop_req) && (sec_err_reg != 8'h0 || mismatch)) begin
                errsec_reg <= errsec_reg + 17'd1;
            end
            if (sec_tick) begin
                elapsed_reg <= elapsed_reg + 17'd1;
                sec_err_reg <= 8'h0;
            end else if (mismatch) begin
                sec_err_reg <= sec_inc;
            end
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    logic tx_reg;
    logic far_loop_reg;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tx_reg <= 1'b1;
            far_loop_reg <= 1'b0;
        end else begin
            far_loop_reg <= far_code_s;
            if (far_loop_reg && !running_reg) begin
                tx_reg <= rx_bit_s;
            end else if (running_reg) begin
                if (bit_en_s) begin
                    tx_reg <= tx_next;
                end
            end else begin
                tx_reg <= sig_tx_bit_in;
            end
        end
    end
    assign tx_bit_out = tx_reg;
    assign test_running_out = running_reg;
    assign link_active_out = !(running_reg || far_loop_reg);
    assign out_of_service_disabled_out = running_reg || far_loop_reg;
    assign looped_state_out = running_reg || far_loop_reg;
    assign associated_state_out = (far_loop_reg && running_reg) ? LBT_ASSOC_FAR_END_AND_TEST
        : far_loop_reg ? LBT_ASSOC_FAR_END : running_reg ? LBT_ASSOC_TEST : LBT_ASSOC_NONE;

    wire [31:0] status_word = {24'h0, seq_abort_reg, far_loop_reg, loop_latched_reg,
        setup_reg, running_reg, 1'b0, done_reg};
    wire [31:0] ctrl_word = {23'h0, loop_latched_reg, last_reg, seq_reg, nonlatch_reg,
        pat_reg, 2'h0};
    wire [31:0] rd_mux = (addr_in == `LBT_ADDR_CTRL) ? ctrl_word
        : (addr_in == `LBT_ADDR_DATA) ? {24'h0, data_reg}
        : (addr_in == `LBT_ADDR_THRESH) ? {8'h0, thresh_reg}
        : (addr_in == `LBT_ADDR_DUR) ? {15'h0, dur_reg}
        : (addr_in == `LBT_ADDR_STATUS) ? status_word
        : (addr_in == `LBT_ADDR_BITERR) ? {24'h0, biterr_reg}
        : (addr_in == `LBT_ADDR_ERRSEC) ? {15'h0, errsec_reg}
        : (addr_in == `LBT_ADDR_ELAPSED) ? {15'h0, elapsed_reg}
        : (addr_in == `LBT_ADDR_LOOPCODE) ? {24'h0, loopcode_reg}
        : (addr_in == `LBT_ADDR_CAPS) ? {25'h0, max_tests} : 32'h0;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 32'h0;
        end else if (rd_in) begin
            rdata_out <= rd_mux;
        end
    end

endmodule // lbt_tester

// *** tb/lbt_tester_props.sv ***
`timescale 1ns/10ps
// ****
// port checks
// ****
module lbt_tester_props
    import lbt_pkg::*;
#(
    parameter int SECOND_CYCLES = 200
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] rdata_out,
    input wire logic bit_en_in,
    input wire logic rx_bit_in,
    input wire logic [6:0] tests_active_in,
    input wire logic [10:0] system_tests_in,
    input wire logic tx_bit_out,
    input wire logic link_active_out,
    input wire logic out_of_service_disabled_out,
    input wire logic looped_state_out,
    input wire lbt_assoc_t associated_state_out,
    input wire logic test_running_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    sequence s_start;
        wr_in && addr_in == 8'h00 && wdata_in[0] && !wdata_in[1] && !wdata_in[6];
    endsequence
    sequence s_stop;
        wr_in && addr_in == 8'h00 && wdata_in[1];
    endsequence
    AST_START_LONG: assert property (
        s_start ##0 (wdata_in[5:2] == 4'h0 && !test_running_out && tests_active_in == 7'h0
        && system_tests_in < 11'd1024) |=> test_running_out && !link_active_out)
        else $error("start write did not start the test");
    AST_STOP: assert property (
        s_stop ##0 test_running_out |=> !test_running_out)
        else $error("stop write did not end the test");
    AST_REFUSE_MODE: assert property (
        s_start ##0 (wdata_in[5] && wdata_in[4:2] >= 3'h2 && !test_running_out)
        |=> !test_running_out)
        else $error("octet mode started without latching");
    AST_SYS_LIMIT: assert property (
        s_start ##0 (system_tests_in >= 11'd1024 && !test_running_out) |=> !test_running_out)
        else $error("start accepted over system limit");
    AST_STATE_TIE: assert property (
        out_of_service_disabled_out == looped_state_out
        && link_active_out == !out_of_service_disabled_out)
        else $error("state outputs disagree");
    AST_ASSOC_RUN: assert property (
        test_running_out == (associated_state_out inside {LBT_ASSOC_TEST,
        LBT_ASSOC_FAR_END_AND_TEST}))
        else $error("associated state does not follow test");
    AST_ASSOC_OOS: assert property (
        out_of_service_disabled_out == (associated_state_out != LBT_ASSOC_NONE))
        else $error("out of service without cause");
    AST_TX_CONT: assert property (
        test_running_out && $past(test_running_out, 4) && $changed(tx_bit_out)
        |-> $past(bit_en_in, 2) || $past(bit_en_in, 3) || $past(bit_en_in, 4))
        else $error("transmit bit moved without bit enable");
    AST_RDATA_HOLD: assert property (
        !$past(rd_in) |-> $stable(rdata_out))
        else $error("read data moved without read");
    AST_UNMAPPED: assert property (
        rd_in && addr_in == 8'h28 |=> rdata_out == 32'h0)
        else $error("unmapped read not zero");
    AST_BITERR_SAT: assert property (
        rd_in && addr_in == 8'h14 |=> rdata_out[31:8] == 24'h0)
        else $error("bit error count above 255");
    AST_FAR_MIRROR: assert property (
        $past(associated_state_out) == LBT_ASSOC_FAR_END |-> tx_bit_out == $past(rx_bit_in, 3))
        else $error("far loop did not return the received bits");
endmodule // lbt_tester_props

bind lbt_tester lbt_tester_props #(.SECOND_CYCLES(SECOND_CYCLES)) u_props (.clk_in,
    .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .bit_en_in, .rx_bit_in,
    .tests_active_in, .system_tests_in, .tx_bit_out, .link_active_out,
    .out_of_service_disabled_out, .looped_state_out, .associated_state_out,
    .test_running_out);

// *** tb/lbt_far_model.sv ***
`timescale 1ns/10ps
// ****
// far line element in loopback
// ****
module lbt_far_model #(
    parameter int GAP = 8
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic tx_bit_in,
    input wire logic invert_in,
    output logic bit_en_out,
    output logic rx_bit_out,
    output logic [15:0] tx_hist_out
);
    logic [7:0] cnt_reg;
    logic [6:0] loop_reg;
    // element stays looped, eight bit round trip
    assign rx_bit_out = loop_reg[6] ^ invert_in;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg <= 8'h0;
            loop_reg <= 7'h0;
            tx_hist_out <= 16'h0;
            bit_en_out <= 1'b0;
        end else begin
            bit_en_out <= (cnt_reg == 8'(GAP - 1));
            cnt_reg <= (cnt_reg == 8'(GAP - 1)) ? 8'h0 : cnt_reg + 8'h1;
            if (bit_en_out) begin
                loop_reg <= {loop_reg[5:0], tx_bit_in};
                tx_hist_out <= {tx_hist_out[14:0], tx_bit_in};
            end
        end
    end
endmodule // lbt_far_model

// *** tb/tb_lbt_tester.sv ***
`timescale 1ns/10ps
// ****
// loop tester bench
// ****
module tb_lbt_tester;
    import lbt_pkg::*;
    localparam int SEC = 8000;
    localparam logic [31:0] CTRL [6] = '{32'h01, 32'h05, 32'h21, 32'h0d, 32'h01, 32'h45};
    localparam logic [31:0] THR [6] = '{56, 56, 56, 56, 56, 32'hffffff};
    localparam logic [31:0] DUR [6] = '{1, 1, 1, 1, 1, 3};
    localparam logic [31:0] ERR [6] = '{0, 0, 0, 0, 57, 255};
    localparam logic [1:0] DONE [6] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2};
    localparam logic [6:0] LIM [4] = '{7'h1, 7'h8, 7'h40, 7'h0};
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic far_code = 1'b0;
    logic [1:0] variant = 2'h1;
    logic [6:0] tests_act = 7'h0;
    logic [10:0] sys_tests = 11'h0;
    logic sig_tx = 1'b1;
    logic invert = 1'b0;
    logic [31:0] rdata;
    logic [31:0] st;
    logic [31:0] d;
    logic bit_en, rx_bit, tx_bit, link_act, oos, looped, running;
    lbt_assoc_t assoc;
    logic [15:0] hist;
    int num_errors = 0;
    int samples_checked = 0;
    int seed = 32'h8dbd122b;
    lbt_tester #(.SECOND_CYCLES(SEC)) dut_u (.clk_in(clk_in), .resetn_in(resetn_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .bit_en_in(bit_en), .rx_bit_in(rx_bit), .far_loop_code_in(far_code),
        .card_variant_in(variant), .tests_active_in(tests_act),
        .system_tests_in(sys_tests), .sig_tx_bit_in(sig_tx), .tx_bit_out(tx_bit),
        .link_active_out(link_act), .out_of_service_disabled_out(oos),
        .looped_state_out(looped), .associated_state_out(assoc), .test_running_out(running));
    lbt_far_model far_u (.clk_in(clk_in), .resetn_in(resetn_in), .tx_bit_in(tx_bit),
        .invert_in(invert), .bit_en_out(bit_en), .rx_bit_out(rx_bit), .tx_hist_out(hist));
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        sig_tx <= 1'($random(seed));
    end
    function automatic logic is_rot(logic [15:0] h, logic [7:0] v);
        logic [15:0] vv;
        vv = {v, v};
        for (int i = 0; i < 8; i++) begin
            if (vv[i +: 8] == h[7:0] && h[15:8] == h[7:0]) begin
                return 1'b1;
            end
        end
        return 1'b0;
    endfunction
    function automatic logic prbs_ok(logic [15:0] h, logic long_pat);
        int a;
        int b;
        a = long_pat ? 11 : 9;
        b = long_pat ? 9 : 5;
        for (int j = 0; j + a < 16; j++) begin
            if (h[j] != (h[j + a] ^ h[j + b])) begin
                return 1'b0;
            end
        end
        return 1'b1;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] dv);
        @(posedge clk_in);
        addr <= a;
        wdata <= dv;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] dv);
        @(posedge clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 dv = rdata;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        reg_rd(a, v);
        check(what, v, exp);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 6000; i++) begin
            reg_rd(8'h10, st);
            if (st[3] !== 1'b1) begin
                break;
            end
        end
    endtask
    task automatic state_chk(input lbt_assoc_t a, input logic busy);
        repeat (8) @(posedge clk_in);
        check("assoc", 32'(assoc), 32'(a));
        check("oos", {31'h0, oos}, {31'h0, a != LBT_ASSOC_NONE});
        check("looped", {31'h0, looped}, {31'h0, a != LBT_ASSOC_NONE});
        check("running", {31'h0, running}, {31'h0, busy});
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge clk_in);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (3) @(posedge clk_in);
        resetn_in <= 1'b1;
        rd_chk("thresh", 8'h08, 32'd56);
        rd_chk("dur", 8'h0c, 32'd1);
        rd_chk("unmapped", 8'h28, 32'h0);
        reg_wr(8'h00, 32'h29);
        check("refused", {31'h0, running}, 32'h0);
        for (int k = 0; k < 4; k++) begin
            variant <= (k == 3) ? 2'h2 : 2'(k);
            tests_act <= LIM[k];
            sys_tests <= (k == 3) ? 11'd1024 : 11'd1;
            repeat (4) @(posedge clk_in);
            reg_wr(8'h00, 32'h01);
            check("over", {31'h0, running}, 32'h0);
            tests_act <= (k < 3) ? LIM[k] - 7'h1 : 7'h0;
            sys_tests <= (k == 3) ? 11'd1023 : 11'd0;
            reg_wr(8'h00, 32'h01);
            check("under", {31'h0, running}, 32'h1);
            reg_wr(8'h00, 32'h02);
        end
        for (int k = 0; k < 2; k++) begin
            d = (k == 0) ? 32'h32 : $random(seed);
            if (k == 1) reg_wr(8'h04, {24'h0, d[7:0]});
            reg_wr(8'h00, 32'h09);
            state_chk(LBT_ASSOC_TEST, 1'b1);
            check("link", {31'h0, link_act}, 32'h0);
            far_code <= 1'b1;
            state_chk(LBT_ASSOC_FAR_END_AND_TEST, 1'b1);
            repeat (3000) @(posedge clk_in);
            check("octet", {31'h0, is_rot(hist, d[7:0])}, 32'h1);
            reg_wr(8'h00, 32'h02);
            reg_rd(8'h10, st);
            check("stopped", {30'h0, st[1:0]}, 32'(LBT_DONE_STOPPED));
            state_chk(LBT_ASSOC_FAR_END, 1'b0);
            far_code <= 1'b0;
            state_chk(LBT_ASSOC_NONE, 1'b0);
        end
        for (int k = 0; k < 6; k++) begin
            invert <= (k > 3);
            reg_wr(8'h08, THR[k]);
            reg_wr(8'h0c, DUR[k]);
            reg_wr(8'h00, CTRL[k]);
            if (k < 2) begin
                repeat (3000) @(posedge clk_in);
                check("prbs", {31'h0, prbs_ok(hist, k == 0)}, 32'h1);
            end
            wait_idle();
            check("done", {30'h0, st[1:0]}, {30'h0, DONE[k]});
            rd_chk("biterr", 8'h14, ERR[k]);
            rd_chk("errsec", 8'h18, {31'h0, k > 3});
            if (k < 4) rd_chk("elapsed", 8'h1c, 32'h1);
        end
        check("aborted", {31'h0, st[7]}, 32'h1);
        reg_wr(8'h00, 32'h41);
        check("seq", {31'h0, running}, 32'h0);
        wrap_up();
    end
endmodule // tb_lbt_tester
